/* rtl/sfmac_consts.svh */
// Timing, slot and sizing constants of the superframe scheduler.
`ifndef SFMAC_CONSTS_SVH
`define SFMAC_CONSTS_SVH

`define SF_SLOTS       16
`define SF_MAX_GTS     7
`define SF_MIN_CAP     5'h02
`define DATA_W         8
`define DL_FIFO_DEPTH  16
`define CLK_PERIOD_NS  4
`define ACK_WAIT_NS    1000
`define ACK_WAIT_CYC   (`ACK_WAIT_NS / `CLK_PERIOD_NS)

`endif

/* rtl/sfmac_pkg.sv */
// Types and the shared period decoder of the superframe scheduler.
`include "sfmac_consts.svh"

package sfmac_pkg;

  typedef enum logic [1:0] {FK_BEACON, FK_DATA, FK_ACK, FK_CMD} frame_kind_t;
  typedef enum logic [1:0] {PER_CAP, PER_CFP, PER_INACTIVE, PER_OFF} period_t;

  // Clamping the free period keeps enough contention room and at most seven slots.
  function automatic period_t period_of(input logic [3:0] slot,
                                        input logic [4:0] active,
                                        input logic [4:0] cfp_first);
    logic [4:0] lo;
    lo = cfp_first;
    if (lo < `SF_MIN_CAP)
    begin
      lo = `SF_MIN_CAP;
    end
    if (active > 5'(`SF_MAX_GTS) && lo < active - 5'(`SF_MAX_GTS))
    begin
      lo = active - 5'(`SF_MAX_GTS);
    end
    if ({1'b0, slot} >= active)
    begin
      return PER_INACTIVE;
    end
    if ({1'b0, slot} >= lo)
    begin
      return PER_CFP;
    end
    return PER_CAP;
  endfunction

endpackage

/* rtl/air_link_if.sv */
// Air link carrying single-beat frames between coordinator and device.
`timescale 1ns/100ps

interface air_link_if;
  import sfmac_pkg::*;
  logic                 c2d_valid;
  frame_kind_t          c2d_kind;
  logic                 c2d_ack_req;
  logic                 c2d_pend;
  logic [`DATA_W-1:0]   c2d_data;
  logic                 d2c_valid;
  frame_kind_t          d2c_kind;
  logic                 d2c_ack_req;
  logic [`DATA_W-1:0]   d2c_data;

  modport coord (output c2d_valid, c2d_kind, c2d_ack_req, c2d_pend, c2d_data,
                 input  d2c_valid, d2c_kind, d2c_ack_req, d2c_data);
  modport dev   (input  c2d_valid, c2d_kind, c2d_ack_req, c2d_pend, c2d_data,
                 output d2c_valid, d2c_kind, d2c_ack_req, d2c_data);
endinterface

/* rtl/sf_coordinator.sv */
// Coordinator end: superframe timer, beacons, pending store and replies.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////

module sf_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [CW-1:0]    count_q;
  logic [CW-1:0]    count_d;
  logic             push;
  logic             pop;

  assign push = in_valid_in && in_ready_out;
  assign pop = out_ready_in && out_valid_out;
  assign count_d = count_q + CW'(push) - CW'(pop);
  assign out_data_out = mem[rd_q];

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
      in_ready_out <= 1'b0;
      out_valid_out <= 1'b0;
    end
    else
    begin
      wr_q <= push ? AW'(wr_q + 1'b1) : wr_q;
      rd_q <= pop ? AW'(rd_q + 1'b1) : rd_q;
      count_q <= count_d;
      in_ready_out <= count_d < CW'(DEPTH);
      out_valid_out <= count_d != '0;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module sf_coordinator
  import sfmac_pkg::*;
(
  // Clock and reset.
  input  wire logic               CLOCK_IN,
  input  wire logic               RST_B_IN,
  // Superframe configuration.
  input  wire logic               BEACON_EN_IN,
  input  wire logic [15:0]        SLOT_LEN_IN,
  input  wire logic [4:0]         ACTIVE_SLOTS_IN,
  input  wire logic [4:0]         CFP_FIRST_IN,
  // Data held for the device.
  input  wire logic               DL_VALID_IN,
  input  wire logic [`DATA_W-1:0] DL_DATA_IN,
  input  wire logic               DL_ACK_REQ_IN,
  output logic                    DL_READY_OUT,
  // Data received from the device.
  output logic                    UL_VALID_OUT,
  output logic [`DATA_W-1:0]      UL_DATA_OUT,
  // Superframe status.
  output logic [3:0]              SLOT_OUT,
  output period_t                 PERIOD_OUT,
  output logic                    LOW_POWER_OUT,
  output logic                    BEACON_OUT,
  // Air link.
  air_link_if.coord               air
);
  typedef enum {C_IDLE, C_SEND, C_WAIT} cstate_t;

  cstate_t            state_q;
  logic [15:0]        tick_q;
  logic [3:0]         slot_q;
  logic               run_q;
  logic               slot_tick;
  logic               sf_start;
  period_t            period;
  logic               cap_ok;
  logic               rx_data;
  logic               rx_cmd;
  logic               rx_ack;
  logic               ack_pend_q;
  logic               ack_bit_q;
  logic               send_ok;
  logic               pop;
  logic [15:0]        wait_q;
  logic               fifo_valid;
  logic [`DATA_W:0]   fifo_head;

  sf_fifo #(.WIDTH(`DATA_W + 1), .DEPTH(`DL_FIFO_DEPTH)) u_pending (
    .clk_in        (CLOCK_IN),
    .rst_b_in      (RST_B_IN),
    .in_valid_in   (DL_VALID_IN),
    .in_data_in    ({DL_ACK_REQ_IN, DL_DATA_IN}),
    .in_ready_out  (DL_READY_OUT),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_head),
    .out_ready_in  (pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configured slot length
  assign slot_tick = run_q && (tick_q == SLOT_LEN_IN - 16'h0001);
  assign sf_start = BEACON_EN_IN && (!run_q || (slot_tick && slot_q == 4'hF));
  assign period = BEACON_EN_IN ? period_of(slot_q, ACTIVE_SLOTS_IN, CFP_FIRST_IN) : PER_OFF;
  assign cap_ok = (period == PER_CAP) || (period == PER_OFF);

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      run_q <= 1'b0;
      tick_q <= 16'h0000;
    end
    else
    begin
      run_q <= BEACON_EN_IN;
      tick_q <= (!BEACON_EN_IN || !run_q || slot_tick) ? 16'h0000 : tick_q + 16'h0001;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      slot_q <= 4'h0;
    end
    else if (sf_start || !BEACON_EN_IN)
    begin
      slot_q <= 4'h0;
    end
    else if (slot_tick)
    begin
      slot_q <= slot_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // three received frame kinds
  assign rx_data = air.d2c_valid && air.d2c_kind == FK_DATA;
  assign rx_cmd = air.d2c_valid && air.d2c_kind == FK_CMD;
  assign rx_ack = air.d2c_valid && air.d2c_kind == FK_ACK;
  assign send_ok = state_q == C_SEND && !sf_start && !ack_pend_q && cap_ok;
  assign pop = (send_ok && !fifo_head[`DATA_W]) || (state_q == C_WAIT && rx_ack);

  // A new request arriving as the old ack leaves keeps the flag set.
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      ack_pend_q <= 1'b0;
      ack_bit_q <= 1'b0;
    end
    else
    begin
      if ((rx_data && air.d2c_ack_req) || rx_cmd)
      begin
        ack_pend_q <= 1'b1;
        ack_bit_q <= rx_cmd && fifo_valid;
      end
      else if (!sf_start)
      begin
        ack_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      state_q <= C_IDLE;
      wait_q <= 16'h0000;
    end
    else
    begin
      unique case (state_q)
        C_IDLE:
        begin
          if (rx_cmd && fifo_valid)
          begin
            state_q <= C_SEND;
          end
        end
        C_SEND:
        begin
          wait_q <= 16'h0000;
          if (send_ok)
          begin
            state_q <= fifo_head[`DATA_W] ? C_WAIT : C_IDLE;
          end
          else if (!cap_ok)
          begin
            state_q <= C_IDLE;
          end
        end
        C_WAIT:
        begin
          wait_q <= wait_q + 16'h0001;
          if (rx_ack || wait_q == 16'(`ACK_WAIT_CYC - 1))
          begin
            state_q <= C_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Beacon beats ack beats data, so a clashing reply slips one cycle.
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      air.c2d_valid <= 1'b0;
      air.c2d_kind <= FK_BEACON;
      air.c2d_ack_req <= 1'b0;
      air.c2d_pend <= 1'b0;
      air.c2d_data <= '0;
    end
    else
    begin
      air.c2d_valid <= sf_start || ack_pend_q || send_ok;
      air.c2d_data <= '0;
      air.c2d_ack_req <= 1'b0;
      if (sf_start)
      begin
        air.c2d_kind <= FK_BEACON;
        air.c2d_pend <= fifo_valid;
      end
      else if (ack_pend_q)
      begin
        air.c2d_kind <= FK_ACK;
        air.c2d_pend <= ack_bit_q;
      end
      else
      begin
        air.c2d_kind <= FK_DATA;
        air.c2d_pend <= 1'b0;
        air.c2d_ack_req <= fifo_head[`DATA_W];
        air.c2d_data <= fifo_head[`DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      UL_VALID_OUT <= 1'b0;
      UL_DATA_OUT <= '0;
      SLOT_OUT <= 4'h0;
      PERIOD_OUT <= PER_OFF;
      LOW_POWER_OUT <= 1'b0;
      BEACON_OUT <= 1'b0;
    end
    else
    begin
      UL_VALID_OUT <= rx_data;
      UL_DATA_OUT <= rx_data ? air.d2c_data : UL_DATA_OUT;
      SLOT_OUT <= slot_q;
      PERIOD_OUT <= period;
      LOW_POWER_OUT <= period == PER_INACTIVE;
      BEACON_OUT <= sf_start;
    end
  end
endmodule

/* rtl/sf_device.sv */
// Device end: beacon tracking, backoff, sending, polling and acknowledging.
`timescale 1ns/100ps

module sf_device
  import sfmac_pkg::*;
(
  // Clock and reset.
  input  wire logic               CLOCK_IN,
  input  wire logic               RST_B_IN,
  // Configuration.
  input  wire logic               BEACON_MODE_IN,
  input  wire logic [15:0]        SLOT_LEN_IN,
  input  wire logic [4:0]         ACTIVE_SLOTS_IN,
  input  wire logic [4:0]         CFP_FIRST_IN,
  input  wire logic               GTS_EN_IN,
  input  wire logic [3:0]         GTS_SLOT_IN,
  input  wire logic               POLL_IN,
  // Data to send to the coordinator.
  input  wire logic               UP_VALID_IN,
  input  wire logic [`DATA_W-1:0] UP_DATA_IN,
  input  wire logic               UP_ACK_REQ_IN,
  output logic                    UP_READY_OUT,
  // Data received from the coordinator.
  output logic                    DN_VALID_OUT,
  output logic [`DATA_W-1:0]      DN_DATA_OUT,
  output logic                    SYNCED_OUT,
  // Air link.
  air_link_if.dev                 air
);
  typedef enum {D_IDLE, D_BACKOFF, D_WAIT_ACK, D_WAIT_DATA} dstate_t;

  dstate_t            state_q;
  logic [15:0]        tick_q;
  logic [3:0]         slot_q;
  logic [7:0]         lfsr_q;
  logic [2:0]         bo_q;
  logic [15:0]        wait_q;
  logic               cmd_q;
  logic               req_want_q;
  logic [`DATA_W-1:0] hold_q;
  logic               hold_ack_q;
  logic               ack_pend_q;
  logic               rx_bcn;
  logic               rx_data;
  logic               rx_ack;
  period_t            period;
  logic               can_start;
  logic               gts_go;
  logic               tx_fire;
  logic               tx_cmd;
  logic               timeout;

  assign rx_bcn = air.c2d_valid && air.c2d_kind == FK_BEACON;
  assign rx_data = air.c2d_valid && air.c2d_kind == FK_DATA;
  assign rx_ack = air.c2d_valid && air.c2d_kind == FK_ACK;
  assign period = SYNCED_OUT ? period_of(slot_q, ACTIVE_SLOTS_IN, CFP_FIRST_IN) : PER_OFF;
  assign can_start = !BEACON_MODE_IN || (SYNCED_OUT && period == PER_CAP
                     && period_of(4'(slot_q + 4'h1), ACTIVE_SLOTS_IN, CFP_FIRST_IN) == PER_CAP);
  assign gts_go = BEACON_MODE_IN && SYNCED_OUT && GTS_EN_IN && period == PER_CFP
                  && slot_q == GTS_SLOT_IN && tick_q == 16'h0000 && !UP_READY_OUT;
  assign tx_fire = !ack_pend_q && ((state_q == D_IDLE && gts_go)
                   || (state_q == D_BACKOFF && can_start && bo_q == 3'h0));
  assign tx_cmd = state_q == D_BACKOFF && cmd_q;
  assign timeout = wait_q == 16'(`ACK_WAIT_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // listen, then synchronise
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      SYNCED_OUT <= 1'b0;
      tick_q <= 16'h0000;
      slot_q <= 4'h0;
    end
    else
    begin
      SYNCED_OUT <= BEACON_MODE_IN && (SYNCED_OUT || rx_bcn);
      if (rx_bcn || !SYNCED_OUT || tick_q == SLOT_LEN_IN - 16'h0001)
      begin
        tick_q <= 16'h0000;
        slot_q <= (rx_bcn || !SYNCED_OUT) ? 4'h0 : slot_q + 4'h1;
      end
      else
      begin
        tick_q <= tick_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A poll arriving as the old one completes is kept.
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      req_want_q <= 1'b0;
      UP_READY_OUT <= 1'b0;
      hold_q <= '0;
      hold_ack_q <= 1'b0;
    end
    else
    begin
      if ((rx_bcn && air.c2d_pend) || (!BEACON_MODE_IN && POLL_IN))
      begin
        req_want_q <= 1'b1;
      end
      else if (state_q == D_WAIT_ACK && rx_ack && cmd_q)
      begin
        req_want_q <= 1'b0;
      end
      if (UP_VALID_IN && UP_READY_OUT)
      begin
        UP_READY_OUT <= 1'b0;
        hold_q <= UP_DATA_IN;
        hold_ack_q <= UP_ACK_REQ_IN;
      end
      else if ((tx_fire && !tx_cmd && !hold_ack_q)
               || (state_q == D_WAIT_ACK && rx_ack && !cmd_q))
      begin
        UP_READY_OUT <= 1'b1;
      end
      else
      begin
        UP_READY_OUT <= UP_READY_OUT | (state_q == D_IDLE && wait_q == 16'hFFFF);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      state_q <= D_IDLE;
      lfsr_q <= 8'h5A;
      bo_q <= 3'h0;
      cmd_q <= 1'b0;
      wait_q <= 16'hFFFF;
    end
    else
    begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      wait_q <= (state_q == D_WAIT_ACK || state_q == D_WAIT_DATA) ? wait_q + 16'h0001 : 16'h0000;
      unique case (state_q)
        D_IDLE:
        begin
          if (tx_fire)
          begin
            cmd_q <= 1'b0;
            state_q <= hold_ack_q ? D_WAIT_ACK : D_IDLE;
          end
          // random backoff first
          // A word meant for the own slot never contends, and nothing is sent before ready rises.
          else if ((req_want_q || (!UP_READY_OUT && !(BEACON_MODE_IN && GTS_EN_IN)
                    && wait_q != 16'hFFFF)) && can_start)
          begin
            cmd_q <= req_want_q;
            bo_q <= lfsr_q[2:0];
            state_q <= D_BACKOFF;
          end
        end
        D_BACKOFF:
        begin
          if (tx_fire)
          begin
            state_q <= (cmd_q || hold_ack_q) ? D_WAIT_ACK : D_IDLE;
          end
          else if (!can_start)
          begin
            state_q <= D_IDLE;
          end
          else if (bo_q != 3'h0)
          begin
            bo_q <= bo_q - 3'h1;
          end
        end
        D_WAIT_ACK:
        begin
          if (rx_ack)
          begin
            state_q <= (cmd_q && air.c2d_pend) ? D_WAIT_DATA : D_IDLE;
          end
          else if (timeout)
          begin
            state_q <= D_IDLE;
          end
        end
        D_WAIT_DATA:
        begin
          if (rx_data || timeout)
          begin
            state_q <= D_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      ack_pend_q <= 1'b0;
      DN_VALID_OUT <= 1'b0;
      DN_DATA_OUT <= '0;
      air.d2c_valid <= 1'b0;
      air.d2c_kind <= FK_DATA;
      air.d2c_ack_req <= 1'b0;
      air.d2c_data <= '0;
    end
    else
    begin
      ack_pend_q <= rx_data && air.c2d_ack_req;
      DN_VALID_OUT <= rx_data;
      DN_DATA_OUT <= rx_data ? air.c2d_data : DN_DATA_OUT;
      air.d2c_valid <= ack_pend_q || tx_fire;
      air.d2c_kind <= ack_pend_q ? FK_ACK : (tx_cmd ? FK_CMD : FK_DATA);
      air.d2c_ack_req <= !ack_pend_q && (tx_cmd || hold_ack_q);
      air.d2c_data <= (ack_pend_q || tx_cmd) ? '0 : hold_q;
    end
  end
endmodule

/* sim/sfmac_props.sv */
// Air-link checker for the coordinator and device pair.
`timescale 1ns/100ps

module sfmac_props
  import sfmac_pkg::*;
#(
  parameter int SF_CYC   = 128,
  parameter int SLOT_CYC = 8,
  parameter int CAP_CYC  = 56,
  parameter int GTS_CYC  = 72
) (
  // Clock and reset.
  input wire logic        CLOCK_IN,
  input wire logic        RST_B_IN,
  // Coordinator to device.
  input wire logic        c2d_valid,
  input wire frame_kind_t c2d_kind,
  input wire logic        c2d_ack_req,
  input wire logic        c2d_pend,
  // Device to coordinator.
  input wire logic        d2c_valid,
  input wire frame_kind_t d2c_kind,
  input wire logic        d2c_ack_req
);
  logic [15:0] cnt_q;
  logic        seen_q;
  logic        bcn;
  logic        c_ack;
  logic        c_dat;
  logic        d_dat;
  logic        in_sf;

  assign bcn   = c2d_valid && c2d_kind == FK_BEACON;
  assign c_ack = c2d_valid && c2d_kind == FK_ACK;
  assign c_dat = c2d_valid && c2d_kind == FK_DATA;
  assign d_dat = d2c_valid && d2c_kind == FK_DATA;
  assign in_sf = seen_q && cnt_q < 16'(SF_CYC);

  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_B_IN);

  ////////////////////////////////////////////////////////////////////////////////

  // The count saturates, so once beacons stop no window check applies.
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      cnt_q <= 16'h0000;
    end
    else if (bcn)
    begin
      cnt_q <= 16'h0001;
    end
    else if (cnt_q != 16'hFFFF)
    begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      seen_q <= 1'b0;
    end
    else if (bcn)
    begin
      seen_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  a_beacon_period: assert property (bcn && seen_q |-> cnt_q == 16'(SF_CYC))
    else $error("beacon spacing wrong");
  a_ack_reply: assert property ((d2c_valid && d2c_ack_req && d2c_kind != FK_ACK)
    |-> ##[2:3] c_ack) else $error("no acknowledgment");
  a_ack_then_data: assert property (c_ack && c2d_pend |-> ##[1:2] c_dat)
    else $error("pending data missing");
  a_empty_no_data: assert property (c_ack && !c2d_pend |=> (!c_dat) [*3])
    else $error("data after empty ack");
  a_dev_ack: assert property (c_dat && c2d_ack_req |-> ##[2:3] (d2c_valid && d2c_kind == FK_ACK))
    else $error("device did not acknowledge");
  a_dev_kinds: assert property (d2c_valid |-> d2c_kind != FK_BEACON)
    else $error("device sent beacon");
  a_coord_data_cap: assert property (c_dat && in_sf |-> cnt_q < 16'(CAP_CYC))
    else $error("coordinator data outside contention");
  a_dev_cap_end: assert property (d_dat && in_sf && cnt_q < 16'(CAP_CYC)
    |-> cnt_q + 4 <= CAP_CYC) else $error("contention data too late");
  a_gts_window: assert property (d_dat && in_sf && cnt_q >= 16'(CAP_CYC)
    |-> cnt_q + 1 >= GTS_CYC && cnt_q + 4 <= GTS_CYC + SLOT_CYC)
    else $error("guaranteed slot data outside its slot");
endmodule

/* sim/tb_top.sv */
// Bench joining coordinator and device over the air link.
`timescale 1ns/100ps

module tb_top;
  import sfmac_pkg::*;
  localparam int SL = 8;
  logic               CLOCK_IN, RST_B_IN, BEACON_EN_IN, GTS_EN_IN, POLL_IN;
  logic               DL_VALID_IN, DL_ACK_REQ_IN, UP_VALID_IN, UP_ACK_REQ_IN;
  logic               DL_READY_OUT, UL_VALID_OUT, LOW_POWER_OUT, BEACON_OUT;
  logic               UP_READY_OUT, DN_VALID_OUT, SYNCED_OUT;
  logic [15:0]        SLOT_LEN_IN;
  logic [4:0]         ACTIVE_SLOTS_IN, CFP_FIRST_IN;
  logic [3:0]         GTS_SLOT_IN, SLOT_OUT;
  logic [`DATA_W-1:0] DL_DATA_IN, UP_DATA_IN, UL_DATA_OUT, DN_DATA_OUT;
  period_t            PERIOD_OUT;
  int                 failures, n_checks, cyc, n, i;

  air_link_if air_link_if_i ();
  sf_coordinator sf_coordinator_i (.*, .air(air_link_if_i));
  sf_device sf_device_i (.*, .BEACON_MODE_IN(BEACON_EN_IN), .air(air_link_if_i));
  sfmac_props #(.SF_CYC(16 * SL), .SLOT_CYC(SL), .CAP_CYC(7 * SL), .GTS_CYC(9 * SL))
    sfmac_props_i (.CLOCK_IN(CLOCK_IN), .RST_B_IN(RST_B_IN),
    .c2d_valid(air_link_if_i.c2d_valid), .c2d_kind(air_link_if_i.c2d_kind),
    .c2d_ack_req(air_link_if_i.c2d_ack_req), .c2d_pend(air_link_if_i.c2d_pend),
    .d2c_valid(air_link_if_i.d2c_valid), .d2c_kind(air_link_if_i.d2c_kind),
    .d2c_ack_req(air_link_if_i.d2c_ack_req));

  ////////////////////////////////////////////////////////////////////////////////

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Samples one step after the edge, when that edge's updates have landed.
  task automatic tick(input int k);
    repeat (k) @(posedge CLOCK_IN);
    #1;
  endtask

  task automatic await(ref logic s, input int lim);
    int k;
    k = 0;
    do
    begin
      tick(1);
      k++;
    end
    while (s !== 1'b1 && k < lim);
    check("await", s, 1'b1);
  endtask

  task automatic count_hi(ref logic s, input int k, output int c);
    c = 0;
    repeat (k)
    begin
      tick(1);
      c += (s === 1'b1);
    end
  endtask

  task automatic up_send(input logic [7:0] d, input logic ack);
    @(posedge CLOCK_IN);
    UP_VALID_IN   <= 1'b1;
    UP_DATA_IN    <= d;
    UP_ACK_REQ_IN <= ack;
    #1;
    for (int k = 0; k < 999 && UP_READY_OUT !== 1'b1; k++) tick(1);
    @(posedge CLOCK_IN);
    UP_VALID_IN <= 1'b0;
    await(UL_VALID_OUT, 400);
    check("uplink data", UL_DATA_OUT, d);
  endtask

  // Pushes back to back; the acknowledge request alternates between words.
  task automatic fill(input int tries, input logic [7:0] base);
    logic acc;
    n = 0;
    @(posedge CLOCK_IN);
    DL_VALID_IN <= 1'b1;
    DL_DATA_IN  <= base;
    #1;
    for (int k = 0; k < tries; k++)
    begin
      acc = (DL_READY_OUT === 1'b1);
      @(posedge CLOCK_IN);
      if (acc)
      begin
        n++;
        DL_DATA_IN    <= base + 8'(n);
        DL_ACK_REQ_IN <= n[0];
      end
      if (k == tries - 1)
      begin
        DL_VALID_IN <= 1'b0;
      end
      #1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////

  initial
  begin
    CLOCK_IN = 1'b0;
    forever #2 CLOCK_IN = ~CLOCK_IN;
  end

  always @(posedge CLOCK_IN)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      summarize();
    end
  end

  initial
  begin
    {RST_B_IN, GTS_EN_IN, POLL_IN, DL_VALID_IN, DL_ACK_REQ_IN, UP_VALID_IN} = 6'h00;
    {BEACON_EN_IN, UP_ACK_REQ_IN} = 2'h3;
    {DL_DATA_IN, UP_DATA_IN} = 16'h0000;
    // Free period asked from slot 5 is pushed to slot 7 by the seven-slot cap.
    SLOT_LEN_IN = 16'(SL);
    ACTIVE_SLOTS_IN = 5'h0E;
    CFP_FIRST_IN = 5'h05;
    GTS_SLOT_IN = 4'h9;
    {failures, n_checks, cyc} = 0;
    repeat (12) @(posedge CLOCK_IN);
    RST_B_IN <= 1'b1;
    await(BEACON_OUT, 400);
    for (i = 0; i < 16; i++)
    begin
      tick(SL / 2);
      check("slot", SLOT_OUT, 16'(i));
      check("period", PERIOD_OUT, i >= 14 ? PER_INACTIVE : i >= 7 ? PER_CFP : PER_CAP);
      check("low power", LOW_POWER_OUT, i >= 14);
      tick(SL / 2);
    end
    check("beacon", BEACON_OUT, 1'b1);
    check("synced", SYNCED_OUT, 1'b1);
    up_send(8'hA5, 1'b1);
    @(posedge CLOCK_IN);
    GTS_EN_IN <= 1'b1;
    up_send(8'h5A, 1'b1);
    @(posedge CLOCK_IN);
    GTS_EN_IN <= 1'b0;
    await(BEACON_OUT, 400);
    fill(20, 8'h10);
    check("fill count", 16'(n), 16'd16);
    check("full refuses", DL_READY_OUT, 1'b0);
    await(BEACON_OUT, 400);
    check("beacon pending", air_link_if_i.c2d_pend, 1'b1);
    for (i = 0; i < 16; i++)
    begin
      await(DN_VALID_OUT, 400);
      check("downlink data", DN_DATA_OUT, 16'h10 + 16'(i));
    end
    await(BEACON_OUT, 400);
    check("beacon cleared", air_link_if_i.c2d_pend, 1'b0);
    @(posedge CLOCK_IN);
    BEACON_EN_IN <= 1'b0;
    count_hi(BEACON_OUT, 300, n);
    check("no beacons", 16'(n), 16'd0);
    fill(1, 8'h77);
    count_hi(DN_VALID_OUT, 200, n);
    check("held data", 16'(n), 16'd0);
    for (i = 0; i < 2; i++)
    begin
      @(posedge CLOCK_IN);
      POLL_IN <= 1'b1;
      @(posedge CLOCK_IN);
      POLL_IN <= 1'b0;
      count_hi(DN_VALID_OUT, 100, n);
      check("poll delivery", 16'(n), 16'(1 - i));
    end
    check("polled data", DN_DATA_OUT, 16'h77);
    up_send(8'hC3, 1'b0);
    summarize();
  end
endmodule
